// >>> verilog/dhps_cfg.svh
// Constants for the tone transceiver host port and steering logic
`ifndef DHPS_CFG_SVH
`define DHPS_CFG_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define DHPS_CLK_MHZ        250
// Reference the far side must feed the oscillator input, in kHz
`define DHPS_OSC_REF_KHZ    3579.545
// Output latch settle time before the delayed steering flag rises
`define DHPS_SETTLE_NS      40
`define DHPS_SETTLE_CYC     ((`DHPS_SETTLE_NS * `DHPS_CLK_MHZ + 999) / 1000)
// Host phase clock high, hold and setup times, in clk cycles
`define DHPS_PH_HIGH_CYC    6
`define DHPS_PH_HOLD_CYC    4
`define DHPS_PH_SETUP_CYC   2

// ----------------------------------------------------------------
// Register select values
// ----------------------------------------------------------------
`define DHPS_SEL_DATA       1'b0
`define DHPS_SEL_CTRL       1'b1

// ----------------------------------------------------------------
// Control A fields
// ----------------------------------------------------------------
`define DHPS_CA_TONE_EN     0
`define DHPS_CA_PROG_MODE   1
`define DHPS_CA_IRQ_EN      2
`define DHPS_CA_SEL_B       3
`define DHPS_CA_RESET       4'h0
`define DHPS_CB_RESET       4'h0

// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define DHPS_STAT_IRQ       0
`define DHPS_STAT_TX_EMPTY  1
`define DHPS_STAT_RX_FULL   2
`define DHPS_STAT_DSTEER    3

`endif

// >>> verilog/dhps_pkg.sv
// Types shared by both ends of the host port
package dhps_pkg;
  typedef logic [3:0] dhps_nib_t;
  typedef enum logic [1:0] {
    DHPS_H_IDLE,
    DHPS_H_SETUP,
    DHPS_H_HIGH,
    DHPS_H_HOLD
  } dhps_hstate_t;
endpackage

// >>> verilog/dhps_if.sv
// Pin-level carrier between host and device
`timescale 1ns/1ps
interface dhps_if;
  logic       phi2;
  logic       cs_n;
  logic       rw;
  logic       reg_sel;
  logic [3:0] h_data_out;
  logic       h_data_oe;
  logic [3:0] d_data_out;
  logic       d_data_oe;
  logic       irq_oe;
  logic [3:0] host_nibble_bus;
  logic       irq_or_tone_out;

  // Bus keeper floats high; open drain line has a pull-up
  assign host_nibble_bus = d_data_oe ? d_data_out : (h_data_oe ? h_data_out : 4'hF);
  assign irq_or_tone_out = ~irq_oe;

  modport host (output phi2, cs_n, rw, reg_sel, h_data_out, h_data_oe,
                input host_nibble_bus, irq_or_tone_out);
  modport dev  (input phi2, cs_n, rw, reg_sel, host_nibble_bus,
                output d_data_out, d_data_oe, irq_oe);
endinterface

// >>> verilog/dhps_dev.sv
// Device end: host port registers, early steering and guard time
// ----------------------------------------------------------------
// Function
// - Respond only while chip select low
// - Release data bus unless selected and phase high
// - Read drives bus, write captures register
// - Register select with read/write picks register
// - Phase clock may stop between accesses
// - Interrupt pin only pulls low
// - Call-progress mode with interrupt enable set: pin follows tone square wave
// - Early steer high on valid tone pair
// - Early steer low on any loss
// - Steer rise registers pair, updates latch
// - Steer low frees acceptance of new pair
// - Guard output from early steer and steer
// - Oscillator fed 3.579545 MHz reference
// - One status, two control, two data registers
// - Registered code latched into receive data
// - Interrupt mode pulls low on delayed steer
// - No tone detection in call-progress mode
// ----------------------------------------------------------------
`timescale 1ns/1ps
`include "dhps_cfg.svh"
module dhps_dev
  import dhps_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst,
  input  wire logic      ce,
  dhps_if.dev            bus,
  input  wire logic      tone_valid,
  input  wire dhps_nib_t tone_code,
  input  wire logic      prog_tone,
  input  wire logic      steer_in,
  output logic           guard_time_out,
  output logic           guard_oe,
  output logic           early_steer,
  output dhps_nib_t      tx_code,
  output logic           tx_load,
  output dhps_nib_t      ctrl_b
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] phi2_s_r;
  logic [1:0] cs_n_s_r;
  logic [1:0] rw_s_r;
  logic [1:0] sel_s_r;
  logic [1:0] steer_s_r;
  logic [1:0] prog_s_r;
  logic [1:0] tv_s_r;
  dhps_nib_t  din_s1_r;
  dhps_nib_t  din_s2_r;
  logic       phi2_d_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phi2_s_r  <= 2'h0;
      cs_n_s_r  <= 2'h3;
      rw_s_r    <= 2'h3;
      sel_s_r   <= 2'h0;
      steer_s_r <= 2'h0;
      prog_s_r  <= 2'h0;
      tv_s_r    <= 2'h0;
      din_s1_r  <= 4'h0;
      din_s2_r  <= 4'h0;
      phi2_d_r  <= 1'b0;
    end else if (ce) begin
      phi2_s_r  <= {phi2_s_r[0], bus.phi2};
      cs_n_s_r  <= {cs_n_s_r[0], bus.cs_n};
      rw_s_r    <= {rw_s_r[0], bus.rw};
      sel_s_r   <= {sel_s_r[0], bus.reg_sel};
      steer_s_r <= {steer_s_r[0], steer_in};
      prog_s_r  <= {prog_s_r[0], prog_tone};
      tv_s_r    <= {tv_s_r[0], tone_valid};
      din_s1_r  <= bus.host_nibble_bus;
      din_s2_r  <= din_s1_r;
      phi2_d_r  <= phi2_s_r[1];
    end
  end

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  // Only edges of the phase clock act, so a stopped clock is harmless
  wire phi2   = phi2_s_r[1];
  wire sel    = ~cs_n_s_r[1];
  wire rd     = rw_s_r[1];
  wire rsel   = sel_s_r[1];
  wire ph_end = phi2_d_r & ~phi2;
  wire acc    = sel & ph_end;
  wire wr_data  = acc & ~rd & (rsel == `DHPS_SEL_DATA);
  wire wr_ctrl  = acc & ~rd & (rsel == `DHPS_SEL_CTRL);
  wire rd_data  = acc & rd & (rsel == `DHPS_SEL_DATA);
  wire rd_stat  = acc & rd & (rsel == `DHPS_SEL_CTRL);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // status, two control, two data
  dhps_nib_t ctrl_a_r;
  dhps_nib_t ctrl_b_r;
  dhps_nib_t tx_r;
  dhps_nib_t rx_r;
  logic      tx_empty_r;
  logic      rx_full_r;
  logic      irq_flag_r;
  logic      tx_load_r;

  wire call_progress_mode = ctrl_a_r[`DHPS_CA_PROG_MODE];
  wire irq_en             = ctrl_a_r[`DHPS_CA_IRQ_EN];

  // ----------------------------------------------------------------
  // Early steering and delayed steering
  // ----------------------------------------------------------------
  logic       early_r;
  logic       steer_d_r;
  logic       dsteer_r;
  logic       settle_on_r;
  logic [7:0] settle_cnt_r;
  logic [7:0] settle_cnt_nxt;

  wire steer      = steer_s_r[1];
  wire steer_rise = steer & ~steer_d_r;
  wire register   = steer_rise & ~call_progress_mode;
  wire settle_done = settle_on_r & (settle_cnt_r == 8'h00);

  always_comb begin
    settle_cnt_nxt = settle_cnt_r;
    if (register) begin
      settle_cnt_nxt = 8'(`DHPS_SETTLE_CYC - 1);
    end else if (settle_on_r && settle_cnt_r != 8'h00) begin
      settle_cnt_nxt = settle_cnt_r - 8'h01;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      early_r      <= 1'b0;
      steer_d_r    <= 1'b0;
      dsteer_r     <= 1'b0;
      settle_on_r  <= 1'b0;
      settle_cnt_r <= 8'h00;
      rx_r         <= 4'h0;
    end else if (ce) begin
      early_r      <= tv_s_r[1] & ~call_progress_mode;
      steer_d_r    <= steer;
      settle_cnt_r <= settle_cnt_nxt;
      if (register) begin
        rx_r        <= tone_code;
        settle_on_r <= 1'b1;
      end else if (settle_done || !steer) begin
        settle_on_r <= 1'b0;
      end
      if (!steer) begin
        dsteer_r <= 1'b0;
      end else if (settle_done) begin
        dsteer_r <= 1'b1;
      end
    end
  end

  wire dsteer_rise = settle_done & steer;

  // ----------------------------------------------------------------
  // Register writes and read side effects
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_a_r   <= `DHPS_CA_RESET;
      ctrl_b_r   <= `DHPS_CB_RESET;
      tx_r       <= 4'h0;
      tx_empty_r <= 1'b1;
      rx_full_r  <= 1'b0;
      irq_flag_r <= 1'b0;
      tx_load_r  <= 1'b0;
    end else if (ce) begin
      tx_load_r <= wr_data;
      if (wr_data) begin
        tx_r       <= din_s2_r;
        tx_empty_r <= 1'b0;
      end else if (tx_load_r) begin
        tx_empty_r <= 1'b1;
      end
      // Bit 3 of control A steers the next control write to B
      if (wr_ctrl) begin
        if (ctrl_a_r[`DHPS_CA_SEL_B]) begin
          ctrl_b_r <= din_s2_r;
          ctrl_a_r[`DHPS_CA_SEL_B] <= 1'b0;
        end else begin
          ctrl_a_r <= din_s2_r;
        end
      end
      // Set wins over read clear
      if (dsteer_rise) begin
        rx_full_r <= 1'b1;
      end else if (rd_data) begin
        rx_full_r <= 1'b0;
      end
      if (dsteer_rise) begin
        irq_flag_r <= 1'b1;
      end else if (rd_stat) begin
        irq_flag_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Host data bus
  // ----------------------------------------------------------------
  dhps_nib_t dout_r;
  wire dhps_nib_t stat_w = {dsteer_r, rx_full_r, tx_empty_r, irq_flag_r};
  wire dhps_nib_t rd_mux = (rsel == `DHPS_SEL_DATA) ? rx_r : stat_w;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dout_r <= 4'h0;
    end else if (ce) begin
      dout_r <= rd_mux;
    end
  end

  assign bus.d_data_out = dout_r;
  // drive only on selected read phase
  assign bus.d_data_oe  = sel & phi2 & rd;

  // ----------------------------------------------------------------
  // Interrupt / call-progress pin
  // ----------------------------------------------------------------
  // square wave follows tone; low on delayed steer
  wire irq_pull = irq_en & (call_progress_mode ? ~prog_s_r[1] : dsteer_r);
  assign bus.irq_oe = irq_pull;

  // ----------------------------------------------------------------
  // Guard time pin
  // ----------------------------------------------------------------
  // drive high once both high, low once both low, else float
  assign guard_time_out = early_r & steer;
  assign guard_oe       = (early_r == steer);

  assign early_steer = early_r;
  assign tx_code     = tx_r;
  assign tx_load     = tx_load_r;
  assign ctrl_b      = ctrl_b_r;

endmodule // dhps_dev

// >>> verilog/dhps_host.sv
// Host end: phase-clocked bus master for the nibble port
`timescale 1ns/1ps
`include "dhps_cfg.svh"
module dhps_host
  import dhps_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst,
  input  wire logic      ce,
  dhps_if.host           bus,
  input  wire logic      req,
  input  wire logic      req_rw,
  input  wire logic      req_sel,
  input  wire dhps_nib_t req_wdata,
  output logic           req_ready,
  output logic           done,
  output dhps_nib_t      rdata,
  output logic           irq_n
);

  // ----------------------------------------------------------------
  // Access sequencer
  // ----------------------------------------------------------------
  dhps_hstate_t state_r;
  logic [3:0]   cnt_r;
  logic         rw_r;
  logic         sel_r;
  dhps_nib_t    wdata_r;
  dhps_nib_t    rdata_r;
  logic         done_r;
  logic [1:0]   irq_s_r;

  wire cnt_zero = (cnt_r == 4'h0);
  assign req_ready = (state_r == DHPS_H_IDLE);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= DHPS_H_IDLE;
      cnt_r   <= 4'h0;
      rw_r    <= 1'b1;
      sel_r   <= 1'b0;
      wdata_r <= 4'h0;
      rdata_r <= 4'h0;
      done_r  <= 1'b0;
      irq_s_r <= 2'h3;
    end else if (ce) begin
      done_r  <= 1'b0;
      irq_s_r <= {irq_s_r[0], bus.irq_or_tone_out};
      if (!cnt_zero) begin
        cnt_r <= cnt_r - 4'h1;
      end
      case (state_r)
        DHPS_H_IDLE: begin
          if (req) begin
            rw_r    <= req_rw;
            sel_r   <= req_sel;
            wdata_r <= req_wdata;
            cnt_r   <= 4'(`DHPS_PH_SETUP_CYC - 1);
            state_r <= DHPS_H_SETUP;
          end
        end
        DHPS_H_SETUP: begin
          if (cnt_zero) begin
            cnt_r   <= 4'(`DHPS_PH_HIGH_CYC - 1);
            state_r <= DHPS_H_HIGH;
          end
        end
        DHPS_H_HIGH: begin
          if (cnt_zero) begin
            // Sample read data at the end of the high phase
            if (rw_r) begin
              rdata_r <= bus.host_nibble_bus;
            end
            cnt_r   <= 4'(`DHPS_PH_HOLD_CYC - 1);
            state_r <= DHPS_H_HOLD;
          end
        end
        DHPS_H_HOLD: begin
          if (cnt_zero) begin
            done_r  <= 1'b1;
            state_r <= DHPS_H_IDLE;
          end
        end
        default: begin
          state_r <= DHPS_H_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  // select low for the access; phase clock idles low
  assign bus.cs_n       = (state_r == DHPS_H_IDLE);
  assign bus.phi2       = (state_r == DHPS_H_HIGH);
  assign bus.rw         = rw_r;
  assign bus.reg_sel    = sel_r;
  assign bus.h_data_out = wdata_r;
  // Hold drives through the hold phase so the device sees stable data
  assign bus.h_data_oe  = ~rw_r & (state_r != DHPS_H_IDLE);

  assign done  = done_r;
  assign rdata = rdata_r;
  assign irq_n = irq_s_r[1];

endmodule // dhps_host

// >>> tb/dhps_properties.sv
// Concurrent checks on the host port, steering pins and host user port
`timescale 1ns/1ps
module dhps_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic phi2,
  input wire logic rw,
  input wire logic d_data_oe,
  input wire logic irq_oe,
  input wire logic irq_or_tone_out,
  input wire logic tone_valid,
  input wire logic early_steer,
  input wire logic steer_in,
  input wire logic guard_time_out,
  input wire logic guard_oe,
  input wire logic req,
  input wire logic req_ready,
  input wire logic done,
  input wire logic irq_n
);
  default clocking dhps_cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // Host port pins
  // ----------------------------------------------------------------
  // Three samples cover the two-flop synchroniser lag
  AST_CS_RELEASE: assert property (cs_n[*3] |-> !d_data_oe)
    else $error("data bus driven while deselected");
  AST_PHI_RELEASE: assert property (!phi2[*3] |-> !d_data_oe)
    else $error("data bus driven while phase clock low");
  AST_WRITE_NO_DRIVE: assert property (!rw[*3] |-> !d_data_oe)
    else $error("data bus driven during write");
  // Pull must reach the host through its two-flop synchroniser
  AST_IRQ_PULL_ONLY: assert property (irq_oe[*3] |-> !irq_n)
    else $error("interrupt pull not seen by host");
  AST_TAKE_SELECT: assert property (req && req_ready |=> !cs_n)
    else $error("chip select not asserted after request");
  AST_DONE_TIME: assert property (req && req_ready |-> ##13 done)
    else $error("access did not finish in 13 cycles");

  // ----------------------------------------------------------------
  // Steering
  // ----------------------------------------------------------------
  AST_EST_RISE: assert property ($rose(tone_valid) ##1 tone_valid[*2] |=> early_steer)
    else $error("early steer late");
  AST_EST_FALL: assert property ($fell(tone_valid) |-> ##3 !early_steer)
    else $error("early steer held after loss");
  AST_GUARD_HIGH: assert property (steer_in[*3] ##0 early_steer |-> guard_oe && guard_time_out)
    else $error("guard not driving high");
  AST_GUARD_LOW: assert property (!steer_in[*3] ##0 !early_steer |-> guard_oe && !guard_time_out)
    else $error("guard not driving low");
  AST_GUARD_FLOAT: assert property (steer_in[*3] ##0 !early_steer |-> !guard_oe)
    else $error("guard driving while states differ");
  AST_GUARD_FLOAT_EST: assert property (!steer_in[*3] ##0 early_steer |-> !guard_oe)
    else $error("guard driving before steer input rises");
endmodule // dhps_properties

// >>> tb/dtmf_host_port_steering_test.sv
// Self-checking bench: host end and device end joined by the pin carrier
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin miscompares++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module dtmf_host_port_steering_test;
  import dhps_pkg::*;
  logic      clk = 1'b0;
  logic      rst = 1'b1;
  logic      req = 1'b0;
  logic      req_rw = 1'b1;
  logic      req_sel = 1'b0;
  dhps_nib_t req_wdata = 4'h0;
  logic      tone_valid = 1'b0;
  dhps_nib_t tone_code = 4'h0;
  logic      prog_tone = 1'b0;
  logic      steer_in = 1'b0;
  logic      req_ready, done, irq_n, guard_time_out, guard_oe, early_steer, tx_load;
  dhps_nib_t rdata, tx_code, ctrl_b, bus_seen;
  int        miscompares = 0;
  int        checks_done = 0;
  int        load_seen = 0;

  always #2 clk = ~clk;

  dhps_if dhps_if_inst ();
  dhps_host dhps_host_inst (.clk(clk), .rst(rst), .ce(1'b1), .bus(dhps_if_inst.host),
    .req(req), .req_rw(req_rw), .req_sel(req_sel), .req_wdata(req_wdata),
    .req_ready(req_ready), .done(done), .rdata(rdata), .irq_n(irq_n));
  dhps_dev dhps_dev_inst (.clk(clk), .rst(rst), .ce(1'b1), .bus(dhps_if_inst.dev),
    .tone_valid(tone_valid), .tone_code(tone_code), .prog_tone(prog_tone), .steer_in(steer_in),
    .guard_time_out(guard_time_out), .guard_oe(guard_oe), .early_steer(early_steer),
    .tx_code(tx_code), .tx_load(tx_load), .ctrl_b(ctrl_b));
  dhps_properties dhps_properties_inst (.clk(clk), .rst(rst), .cs_n(dhps_if_inst.cs_n),
    .phi2(dhps_if_inst.phi2), .rw(dhps_if_inst.rw), .d_data_oe(dhps_if_inst.d_data_oe),
    .irq_oe(dhps_if_inst.irq_oe), .irq_or_tone_out(dhps_if_inst.irq_or_tone_out),
    .tone_valid(tone_valid), .early_steer(early_steer), .steer_in(steer_in),
    .guard_time_out(guard_time_out), .guard_oe(guard_oe), .req(req),
    .req_ready(req_ready), .done(done), .irq_n(irq_n));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic final_report;
    if (miscompares == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One access; also captures what the device put on the wire
  task automatic acc(input logic rw_i, input logic sel_i, input dhps_nib_t wd);
    int n;
    n = 0;
    load_seen = 0;
    bus_seen = 4'hX;
    @(posedge clk);
    req <= 1'b1; req_rw <= rw_i; req_sel <= sel_i; req_wdata <= wd;
    @(posedge clk);
    req <= 1'b0;
    @(negedge clk);
    while (done !== 1'b1 && n < 40) begin
      if (dhps_if_inst.d_data_oe === 1'b1) bus_seen = dhps_if_inst.host_nibble_bus;
      if (tx_load === 1'b1) load_seen++;
      @(negedge clk);
      n++;
    end
    if (n == 40) begin
      miscompares++;
      final_report();
    end
    `CHK(dhps_if_inst.host_nibble_bus, 4'hF)
  endtask

  task automatic rd(input logic sel_i, input dhps_nib_t exp);
    acc(1'b1, sel_i, 4'h0);
    `CHK(rdata, exp)
    `CHK(bus_seen, exp)
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    `CHK(dhps_if_inst.cs_n, 1'b1)
    `CHK(irq_n, 1'b1)
    rd(1'b1, 4'h2);
  endtask

  task automatic t_write;
    acc(1'b0, 1'b0, 4'hA);
    `CHK(tx_code, 4'hA)
    `CHK(load_seen, 1)
    acc(1'b0, 1'b1, 4'h8);
    `CHK(load_seen, 0)
    acc(1'b0, 1'b1, 4'h5);
    `CHK(ctrl_b, 4'h5)
  endtask

  task automatic t_steer;
    acc(1'b0, 1'b1, 4'h4);
    @(posedge clk);
    tone_code <= 4'h9; tone_valid <= 1'b1;
    tick(6);
    `CHK(early_steer, 1'b1)
    steer_in <= 1'b1;
    tick(24);
    `CHK(irq_n, 1'b0)
    rd(1'b1, 4'hF);
    rd(1'b0, 4'h9);
    @(posedge clk);
    tone_valid <= 1'b0;
    tick(6);
    `CHK(early_steer, 1'b0)
    steer_in <= 1'b0;
    tick(8);
    `CHK(irq_n, 1'b1)
  endtask

  task automatic t_call_progress;
    acc(1'b0, 1'b1, 4'h6);
    tick(8);
    `CHK(irq_n, 1'b0)
    prog_tone <= 1'b1;
    tick(8);
    `CHK(irq_n, 1'b1)
    tone_code <= 4'h3; steer_in <= 1'b1;
    tick(20);
    steer_in <= 1'b0;
    rd(1'b0, 4'h9);
    rd(1'b1, 4'h2);
    acc(1'b0, 1'b1, 4'h0);
  endtask

  initial begin
    tick(6);
    rst <= 1'b0;
    t_reset();
    t_write();
    t_steer();
    t_call_progress();
    final_report();
  end
endmodule // dtmf_host_port_steering_test
